// ==== uodc_device.sv ====
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`include "uodc_params.svh"
module uodc_device #(
	parameter int NUM_EP = 7,
	parameter int SUSP_TO_CYC = `UODC_SUSP_TO_MS * `UODC_CLK_KHZ,
	parameter int CONN_TO_CYC = `UODC_CONN_TO_MS * `UODC_CLK_KHZ
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Power-up reset, sync
	input wire logic cyc_i, // Wishbone cycle
	input wire logic stb_i, // Wishbone strobe
	input wire logic we_i, // Wishbone write
	input wire logic [7:0] adr_i, // Byte address
	input wire logic [3:0] sel_i, // Byte lanes
	input wire logic [31:0] dat_i, // Write data
	output logic [31:0] dat_o, // Read data
	output logic ack_o, // Wishbone ack
	output logic otg_irq_o, // OTG interrupt request
	uodc_link_if.dev link // Bus side
);
	// Size limits are fixed per endpoint number
	generate
		if (NUM_EP != 7 || SUSP_TO_CYC < 2 || CONN_TO_CYC < 2) begin : g_chk
			$error("uodc_device: unsupported parameters");
		end
	endgenerate

	// Legal configuration: size code within the endpoint's limit, no bank on endpoint 0
	function automatic logic uodc_cfg_ok(input int ep, input logic [2:0] sz,
		input logic bk);
		logic [2:0] lim;
		lim = (ep == 1) ? `UODC_SZ_MAX_EP1 : `UODC_SZ_MAX;
		return (sz <= lim) && !(ep == 0 && bk);
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	logic ack_ff, en_ff, host_ff, frz_ff, det_ff, crst, wr;
	logic [31:0] dat_ff;
	logic [7:0] d, rd;
	logic hnp_ff, vreq_ff, irq_ff, pull_ff, brst_q_ff, eorst_ff, speed_ff;
	logic brst_end, tok_go, tok_ok, tack_ff, tnak_ff, susp_hit, conn_hit;
	logic [1:0] page_ff;
	logic [1:0] tval_ff [4];
	logic [5:0] oen_ff, ofl_ff, ev;
	logic [31:0] susp_cnt_ff, conn_cnt_ff;
	logic [6:0] addr_ff, cur_addr;
	logic aen_ff;
	logic [2:0] sel_ep_ff;
	logic [NUM_EP-1:0] ep_en_ff, ep_tog_ff, ep_evt_ff, ep_bk_ff, ep_al_ff;
	logic [NUM_EP-1:0] cfg_good, tok_hit;
	logic [2:0] ep_sz_ff [NUM_EP];
	logic sel_ok;

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave
	////////////////////////////////////////////////////////////////////////

	// Write lands on the edge at which the master sees ack
	assign wr = cyc_i & stb_i & we_i & ack_ff & sel_i[0];
	assign d = dat_i[7:0];
	// Controller state is cleared by power-up or by disable
	assign crst = rst_i | ~en_ff;

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= cyc_i & stb_i & ~ack_ff;
			dat_ff <= {24'h00_0000, rd};
		end
	end
	assign ack_o = ack_ff;
	assign dat_o = dat_ff;

	assign sel_ok = 32'(sel_ep_ff) < NUM_EP;

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd = 8'h00;
		case (adr_i)
			`UODC_A_CTRL: rd = {en_ff, host_ff, frz_ff, 4'h0, det_ff};
			`UODC_A_TIMER: rd = {1'b1, page_ff, 3'h0, tval_ff[page_ff]};
			`UODC_A_OTGEN: rd = {2'h0, oen_ff};
			`UODC_A_OTGFL: rd = {2'h0, ofl_ff};
			`UODC_A_STAT: rd = {3'h0, eorst_ff, speed_ff, 1'b0, pull_ff,
				link.vbus_present};
			`UODC_A_EPSEL: rd = {5'h00, sel_ep_ff};
			`UODC_A_EPCFG: if (sel_ok) begin
				rd = {cfg_good[sel_ep_ff], 1'b0, ep_al_ff[sel_ep_ff],
					ep_bk_ff[sel_ep_ff], ep_sz_ff[sel_ep_ff],
					ep_en_ff[sel_ep_ff]};
			end
			`UODC_A_ADDR: rd = {aen_ff, addr_ff};
			`UODC_A_EPEVT: if (sel_ok) begin
				rd = {6'h00, ep_tog_ff[sel_ep_ff], ep_evt_ff[sel_ep_ff]};
			end
			// Request clear bit always reads zero
			`UODC_A_OTGCON: rd = {2'h0, hnp_ff, 3'h0, vreq_ff, 1'b0};
			default: rd = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Global control and OTG
	////////////////////////////////////////////////////////////////////////

	// Comes up frozen and detached
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_ff <= 1'b0;
			host_ff <= 1'b0;
			{frz_ff, det_ff} <= 2'(`UODC_CTRL_RST);
		end else if (wr && hit(adr_i, `UODC_A_CTRL)) begin
			en_ff <= d[`UODC_B_EN];
			host_ff <= d[`UODC_B_HOST];
			frz_ff <= d[`UODC_B_FRZ];
			det_ff <= d[`UODC_B_DET];
		end
	end

	// Timer page and one stored value per page
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			page_ff <= 2'h0;
			tval_ff <= '{default: 2'h0};
		end else if (wr && hit(adr_i, `UODC_A_TIMER)) begin
			page_ff <= d[6:5];
			tval_ff[d[6:5]] <= d[1:0];
		end
	end

	// VBUS request; clear bit and missing peer both drop it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hnp_ff <= 1'b0;
			vreq_ff <= 1'b0;
		end else begin
			if (wr && hit(adr_i, `UODC_A_OTGCON)) begin
				hnp_ff <= d[`UODC_B_HNPREQ];
				vreq_ff <= d[`UODC_B_VREQ] & ~d[`UODC_B_VCLR];
			end
			if (conn_hit) begin
				vreq_ff <= 1'b0;
			end
		end
	end
	assign link.vbus_power = vreq_ff;

	// Peer must connect while VBUS is being delivered
	always_ff @(posedge clk_i) begin
		if (rst_i || !vreq_ff || link.peer_connect) begin
			conn_cnt_ff <= 32'h0000_0000;
		end else begin
			conn_cnt_ff <= conn_cnt_ff + 32'h0000_0001;
		end
	end
	assign conn_hit = conn_cnt_ff == 32'(CONN_TO_CYC - 1);

	// Suspend watchdog saturates so it fires once per suspend
	always_ff @(posedge clk_i) begin
		if (rst_i || !link.suspend || !hnp_ff) begin
			susp_cnt_ff <= 32'h0000_0000;
		end else if (susp_cnt_ff != 32'(SUSP_TO_CYC)) begin
			susp_cnt_ff <= susp_cnt_ff + 32'h0000_0001;
		end
	end
	assign susp_hit = susp_cnt_ff == 32'(SUSP_TO_CYC - 1);

	// Event sources, one bit per flag
	assign ev = {susp_hit, link.neg_error, link.role_swap, conn_hit,
		link.vbus_drop, link.srp & host_ff};

	// Flags: write zero clears, a new event wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ofl_ff <= 6'h00;
		end else if (wr && hit(adr_i, `UODC_A_OTGFL)) begin
			ofl_ff <= (ofl_ff & d[5:0]) | ev;
		end else begin
			ofl_ff <= ofl_ff | ev;
		end
	end

	// Enables share bit positions with the flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oen_ff <= 6'h00;
			irq_ff <= 1'b0;
		end else begin
			if (wr && hit(adr_i, `UODC_A_OTGEN)) begin
				oen_ff <= d[5:0];
			end
			irq_ff <= |(ofl_ff & oen_ff);
		end
	end
	assign otg_irq_o = irq_ff;

	////////////////////////////////////////////////////////////////////////
	// Device controller
	////////////////////////////////////////////////////////////////////////

	// Bus reset seen even while frozen
	assign brst_end = brst_q_ff & ~link.bus_reset;

	// Attach, bus reset end, speed
	always_ff @(posedge clk_i) begin
		if (crst) begin
			pull_ff <= 1'b0;
			brst_q_ff <= 1'b0;
			eorst_ff <= 1'b0;
			speed_ff <= 1'b0;
		end else begin
			pull_ff <= ~det_ff & link.vbus_present;
			brst_q_ff <= link.bus_reset;
			if (wr && hit(adr_i, `UODC_A_STAT)) begin
				eorst_ff <= eorst_ff & d[4];
			end
			if (brst_end) begin
				eorst_ff <= 1'b1;
				speed_ff <= link.speed_full;
			end
		end
	end
	assign link.dp_pullup = pull_ff;

	// Address and select; firmware sets enable in a later write
	always_ff @(posedge clk_i) begin
		if (crst) begin
			addr_ff <= 7'h00;
			aen_ff <= 1'b0;
			sel_ep_ff <= 3'h0;
		end else begin
			if (wr && hit(adr_i, `UODC_A_ADDR)) begin
				addr_ff <= d[6:0];
				aen_ff <= d[`UODC_B_ADR_ON];
			end
			if (wr && hit(adr_i, `UODC_A_EPSEL)) begin
				sel_ep_ff <= d[2:0];
			end
			if (link.bus_reset) begin
				addr_ff <= 7'h00;
				aen_ff <= 1'b0;
			end
		end
	end
	assign cur_addr = aen_ff ? addr_ff : 7'h00;

	// Frozen clock: no token is served
	assign tok_go = link.tok_valid & ~frz_ff & pull_ff &
		(link.tok_addr == cur_addr) & (32'(link.tok_ep) < NUM_EP);
	assign tok_ok = tok_go && ep_en_ff[link.tok_ep] && cfg_good[link.tok_ep];

	// Handshake answer one cycle after the token
	always_ff @(posedge clk_i) begin
		if (crst) begin
			tack_ff <= 1'b0;
			tnak_ff <= 1'b0;
		end else begin
			tack_ff <= tok_ok;
			tnak_ff <= tok_go & ~tok_ok;
		end
	end
	assign link.tok_ack = tack_ff;
	assign link.tok_nak = tnak_ff;

	// Per-endpoint configuration and state
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
			logic cw, ew, rs;
			assign cfg_good[gi] = uodc_cfg_ok(gi, ep_sz_ff[gi],
				ep_bk_ff[gi]);
			assign tok_hit[gi] = tok_ok && (32'(link.tok_ep) == gi);
			assign cw = wr && hit(adr_i, `UODC_A_EPCFG) && (32'(sel_ep_ff) == gi);
			assign ew = wr && hit(adr_i, `UODC_A_EPEVT) && (32'(sel_ep_ff) == gi);
			assign rs = wr && hit(adr_i, `UODC_A_EPRST) && d[gi];

			always_ff @(posedge clk_i) begin
				if (crst) begin
					ep_en_ff[gi] <= 1'b0;
					ep_sz_ff[gi] <= 3'h0;
					ep_bk_ff[gi] <= 1'b0;
					ep_al_ff[gi] <= 1'b0;
				end else begin
					if (cw) begin
						ep_en_ff[gi] <= d[`UODC_B_EP_ON];
						ep_sz_ff[gi] <= d[3:1];
						ep_bk_ff[gi] <= d[`UODC_B_BANK];
						ep_al_ff[gi] <= d[`UODC_B_MEM_RES];
					end
					if (link.bus_reset && gi != 0) begin
						ep_en_ff[gi] <= 1'b0;
					end
				end
			end

			// Toggle survives endpoint reset, not enable clear
			always_ff @(posedge clk_i) begin
				if (crst) begin
					ep_tog_ff[gi] <= 1'b0;
				end else if (cw && (d[`UODC_B_TOGRST] || !d[`UODC_B_EP_ON])) begin
					ep_tog_ff[gi] <= 1'b0;
				end else if (tok_hit[gi]) begin
					ep_tog_ff[gi] <= ~ep_tog_ff[gi];
				end
			end

			// Event bit held clear while disabled or in endpoint reset; set wins over write clear
			always_ff @(posedge clk_i) begin
				if (crst || !ep_en_ff[gi] || rs) begin
					ep_evt_ff[gi] <= 1'b0;
				end else if (ew) begin
					ep_evt_ff[gi] <= (ep_evt_ff[gi] & d[0]) | tok_hit[gi];
				end else begin
					ep_evt_ff[gi] <= ep_evt_ff[gi] | tok_hit[gi];
				end
			end
		end
	endgenerate
endmodule

// ==== uodc_host.sv ====
`include "uodc_params.svh"
module uodc_host #(
	parameter int BRST_CYC = `UODC_BRST_CYC
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Sync reset
	input wire logic vbus_on_i, // VBUS present level
	input wire logic speed_full_i, // Full speed level
	input wire logic connect_i, // Peripheral connected
	input wire logic suspend_i, // Line suspended
	input wire logic srp_i, // Session request pulse
	input wire logic neg_err_i, // Negotiation error pulse
	input wire logic role_swap_i, // Role swap done pulse
	input wire logic vbus_drop_i, // VBUS drop pulse
	input wire logic bus_reset_i, // Start a bus reset
	input wire logic tok_req_i, // Send a token
	input wire logic [6:0] tok_addr_i, // Token address
	input wire logic [2:0] tok_ep_i, // Token endpoint
	output logic busy_o, // Sequencer busy
	output logic done_o, // Token finished pulse
	output logic acked_o, // Token acknowledged
	output logic naked_o, // Token refused
	output logic pullup_o, // Device pull-up seen
	output logic vbus_power_o, // Power request seen
	uodc_link_if.host link // Device side
);
	generate
		if (BRST_CYC < 1) begin : g_chk
			$error("uodc_host: BRST_CYC must be positive");
		end
	endgenerate

	uodc_pkg::uodc_hstate_t st_ff;
	logic [31:0] cnt_ff;
	logic [3:0] lvl_ff;
	logic [3:0] ev_ff;
	logic tv_ff, done_ff, ack_ff, nak_ff, pu_ff, vp_ff;
	logic [6:0] ta_ff;
	logic [2:0] te_ff;

	// Line levels and event pulses, registered once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_ff <= 4'h0;
			ev_ff <= 4'h0;
			pu_ff <= 1'b0;
			vp_ff <= 1'b0;
		end else begin
			lvl_ff <= {vbus_on_i, speed_full_i, connect_i, suspend_i};
			ev_ff <= {srp_i, neg_err_i, role_swap_i, vbus_drop_i};
			pu_ff <= link.dp_pullup;
			vp_ff <= link.vbus_power;
		end
	end
	assign {link.vbus_present, link.speed_full, link.peer_connect} = lvl_ff[3:1];
	assign link.suspend = lvl_ff[0];
	assign {link.srp, link.neg_error, link.role_swap, link.vbus_drop} = ev_ff;
	assign pullup_o = pu_ff;
	assign vbus_power_o = vp_ff;

	// Bus reset and token sequencer; waits are bounded
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= uodc_pkg::UODC_H_IDLE;
			cnt_ff <= 32'h0000_0000;
			tv_ff <= 1'b0;
			ta_ff <= 7'h00;
			te_ff <= 3'h0;
			done_ff <= 1'b0;
			ack_ff <= 1'b0;
			nak_ff <= 1'b0;
		end else begin
			tv_ff <= 1'b0;
			done_ff <= 1'b0;
			cnt_ff <= cnt_ff + 32'h0000_0001;
			case (st_ff)
				uodc_pkg::UODC_H_IDLE: begin
					cnt_ff <= 32'h0000_0000;
					if (bus_reset_i) begin
						st_ff <= uodc_pkg::UODC_H_RST;
					end else if (tok_req_i) begin
						tv_ff <= 1'b1;
						ta_ff <= tok_addr_i;
						te_ff <= tok_ep_i;
						ack_ff <= 1'b0;
						nak_ff <= 1'b0;
						st_ff <= uodc_pkg::UODC_H_WAIT;
					end
				end
				uodc_pkg::UODC_H_RST: begin
					if (cnt_ff == 32'(BRST_CYC - 1)) begin
						st_ff <= uodc_pkg::UODC_H_IDLE;
					end
				end
				uodc_pkg::UODC_H_WAIT: begin
					if (link.tok_ack || link.tok_nak ||
						cnt_ff == 32'(`UODC_RESP_CYC)) begin
						ack_ff <= link.tok_ack;
						nak_ff <= link.tok_nak;
						done_ff <= 1'b1;
						st_ff <= uodc_pkg::UODC_H_IDLE;
					end
				end
				default: st_ff <= uodc_pkg::UODC_H_IDLE;
			endcase
		end
	end
	assign link.bus_reset = st_ff == uodc_pkg::UODC_H_RST;
	assign link.tok_valid = tv_ff;
	assign link.tok_addr = ta_ff;
	assign link.tok_ep = te_ff;
	assign busy_o = st_ff != uodc_pkg::UODC_H_IDLE;
	assign done_o = done_ff;
	assign acked_o = ack_ff;
	assign naked_o = nak_ff;
endmodule

// ==== uodc_link_checker.sv ====
module uodc_link_checker #(
	parameter int CONN_TO_CYC = 30
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Sync reset
	input wire logic vbus_present, // VBUS level
	input wire logic peer_connect, // Peer attached
	input wire logic tok_valid, // Token strobe
	input wire logic [2:0] tok_ep, // Token endpoint
	input wire logic tok_ack, // Token acked
	input wire logic tok_nak, // Token refused
	input wire logic dp_pullup, // Device pull-up
	input wire logic vbus_power // Power request
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////
	// Unanswered power request age; slack covers the request register lag
	int cnt_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i || !vbus_power || peer_connect)
			cnt_ff <= 0;
		else
			cnt_ff <= cnt_ff + 1;
	end
	////////////////////////////////////////////////////////////////////////
	// Token answers
	a_ans_exclusive: assert property (!(tok_ack && tok_nak))
		else $error("ack and nak in one cycle");
	a_ans_needs_token: assert property (
		(tok_ack || tok_nak) |-> $past(tok_valid))
		else $error("answer without a token one cycle before");
	a_ans_one_cycle: assert property (
		tok_ack |=> !tok_ack && !tok_nak)
		else $error("answer longer than one cycle");
	a_ep7_silent: assert property (
		tok_valid && tok_ep == 3'h7 |=> !tok_ack && !tok_nak)
		else $error("answer to a missing endpoint");
	// Pull-up and power
	a_pullup_rise_vbus: assert property (
		$rose(dp_pullup) |-> $past(vbus_present))
		else $error("pull-up raised without VBUS");
	a_pullup_drop: assert property (!vbus_present |=> !dp_pullup)
		else $error("pull-up kept after VBUS loss");
	a_reset_detached: assert property (
		$past(rst_i) |-> !dp_pullup && !vbus_power)
		else $error("pull-up or power on after reset");
	a_conn_timeout: assert property (cnt_ff <= CONN_TO_CYC + 2)
		else $error("power request outlived connect timeout");
endmodule

// ==== uodc_link_if.sv ====
interface uodc_link_if;
	logic vbus_present;
	logic bus_reset;
	logic speed_full;
	logic peer_connect;
	logic suspend;
	logic srp;
	logic neg_error;
	logic role_swap;
	logic vbus_drop;
	logic tok_valid;
	logic [6:0] tok_addr;
	logic [2:0] tok_ep;
	logic dp_pullup;
	logic vbus_power;
	logic tok_ack;
	logic tok_nak;
	modport dev(input vbus_present, bus_reset, speed_full, peer_connect,
		suspend, srp, neg_error, role_swap, vbus_drop, tok_valid, tok_addr,
		tok_ep, output dp_pullup, vbus_power, tok_ack, tok_nak);
	modport host(output vbus_present, bus_reset, speed_full, peer_connect,
		suspend, srp, neg_error, role_swap, vbus_drop, tok_valid, tok_addr,
		tok_ep, input dp_pullup, vbus_power, tok_ack, tok_nak);
endinterface

// ==== uodc_params.svh ====
// Overview of operation
// - Request clear bit drops VBUS power, self-clears
// - Timer register: bit7 one, page, value
// - One enable per OTG flag, same bit
// - Suspend timeout over 150 ms sets flag; counted only while the HNP request bit is set
// - Negotiation error and VBUS drop set flags
// - Role swap sets flag, mode bit unchanged
// - No connection within 300 ms sets flag
// - Session request sets flag in host mode
// - Firmware powers up in documented order
// - Firmware suspends and resumes in documented order
// - Seven endpoints with per-endpoint size limits
// - Reset: frozen, detached, banks cleared, no pull-up
// - Pull-up only when attached and VBUS present
// - Clearing controller enable resets the controller
// - Bus reset end sets flag, speed latched
// - Endpoint reset clears state, keeps toggle, configuration
// - Bus reset disables endpoints except control
// - Endpoint select routes endpoint register access
// - Disabled or misconfigured endpoint never acknowledges
// - Enable clear resets endpoint and toggle
// - Answer address zero until address enabled
// - Address enable cleared by resets and disable
// - Freeze stops controller, bus reset still seen
`ifndef UODC_PARAMS_SVH
`define UODC_PARAMS_SVH

// Register offsets, byte addresses on the bus
`define UODC_A_CTRL 8'h00
`define UODC_A_TIMER 8'h04
`define UODC_A_OTGEN 8'h08
`define UODC_A_OTGFL 8'h0C
`define UODC_A_STAT 8'h10
`define UODC_A_EPSEL 8'h14
`define UODC_A_EPCFG 8'h18
`define UODC_A_EPRST 8'h1C
`define UODC_A_ADDR 8'h20
`define UODC_A_EPEVT 8'h24
`define UODC_A_OTGCON 8'h28

// Field positions
`define UODC_B_EN 7
`define UODC_B_HOST 6
`define UODC_B_FRZ 5
`define UODC_B_DET 0
`define UODC_B_HNPREQ 5
`define UODC_B_VREQ 1
`define UODC_B_VCLR 0
`define UODC_B_TFIX 7
`define UODC_B_EP_ON 0
`define UODC_B_BANK 4
`define UODC_B_MEM_RES 5
`define UODC_B_TOGRST 6
`define UODC_B_CFG_GOOD 7
`define UODC_B_ADR_ON 7

// Reset values and size limits
`define UODC_CTRL_RST 4'h3
`define UODC_SZ_MAX_EP1 3'h5
`define UODC_SZ_MAX 3'h3

// Timing, times as printed and clock rate
`define UODC_CLK_KHZ 100000
`define UODC_SUSP_TO_MS 150
`define UODC_CONN_TO_MS 300
`define UODC_BRST_CYC 32
`define UODC_RESP_CYC 8'h08

`endif

// ==== uodc_pkg.sv ====
package uodc_pkg;
	// Far-end sequencer states, one-hot
	typedef enum logic [2:0] {
		UODC_H_IDLE = 3'h1,
		UODC_H_RST = 3'h2,
		UODC_H_WAIT = 3'h4
	} uodc_hstate_t;
	typedef logic [7:0] uodc_reg_t;
endpackage

// ==== usb_otg_device_control_tb.sv ====
`include "uodc_params.svh"
module usb_otg_device_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dw = 32'h0000_0000;
	logic [31:0] dr;
	logic ack, irq, busy, done, acked, naked, pu, vpw;
	logic vbus_on = 1'b1, spd = 1'b0, conn = 1'b0, susp = 1'b0;
	logic [3:0] ev = 4'h0;
	logic brst = 1'b0, treq = 1'b0;
	logic [6:0] taddr = 7'h00;
	logic [2:0] tep = 3'h0;
	logic [31:0] seed = 32'hc06a_00d7;
	logic [7:0] rq[$];
	logic [1:0] tq[$];
	int fails = 0, n_checks = 0;
	////////////////////////////////////////////////////////////////////////
	// Clock, both ends and the wire checker
	always #5 clk_i = ~clk_i;
	uodc_link_if uodc_link_if_i ();
	uodc_device #(.SUSP_TO_CYC(20), .CONN_TO_CYC(30)) uodc_device_i (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'h1), .dat_i(dw), .dat_o(dr), .ack_o(ack),
		.otg_irq_o(irq), .link(uodc_link_if_i));
	uodc_host #(.BRST_CYC(8)) uodc_host_i (
		.clk_i(clk_i), .rst_i(rst_i), .vbus_on_i(vbus_on),
		.speed_full_i(spd), .connect_i(conn), .suspend_i(susp),
		.srp_i(ev[3]), .neg_err_i(ev[2]), .role_swap_i(ev[1]),
		.vbus_drop_i(ev[0]), .bus_reset_i(brst), .tok_req_i(treq),
		.tok_addr_i(taddr), .tok_ep_i(tep), .busy_o(busy), .done_o(done),
		.acked_o(acked), .naked_o(naked), .pullup_o(pu),
		.vbus_power_o(vpw), .link(uodc_link_if_i));
	uodc_link_checker #(.CONN_TO_CYC(30)) uodc_link_checker_i (
		.clk_i(clk_i), .rst_i(rst_i),
		.vbus_present(uodc_link_if_i.vbus_present),
		.peer_connect(uodc_link_if_i.peer_connect),
		.tok_valid(uodc_link_if_i.tok_valid),
		.tok_ep(uodc_link_if_i.tok_ep), .tok_ack(uodc_link_if_i.tok_ack),
		.tok_nak(uodc_link_if_i.tok_nak),
		.dp_pullup(uodc_link_if_i.dp_pullup),
		.vbus_power(uodc_link_if_i.vbus_power));
	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] z(input logic v);
		return {31'h0000_0000, v};
	endfunction
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic w(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// Classic cycle: held until ack is sampled, then released
	task automatic bus(input logic wr_en, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr_en;
		adr <= a;
		dw <= {24'h00_0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			fails++;
			results();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask
	// Token with expected {acked, naked}; 0 means no answer
	task automatic tk(input logic [6:0] a, input logic [2:0] e,
		input logic [1:0] x);
		int n;
		n = 0;
		tq.push_back(x);
		@(posedge clk_i);
		treq <= 1'b1;
		taddr <= a;
		tep <= e;
		@(posedge clk_i);
		treq <= 1'b0;
		while (done !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 50) begin
			fails++;
			results();
		end
	endtask
	task automatic bres();
		int n;
		n = 0;
		@(posedge clk_i);
		brst <= 1'b1;
		@(posedge clk_i);
		brst <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (busy !== 1'b0 && n < 50);
		if (n >= 50) begin
			fails++;
			results();
		end
		w(3);
	endtask
	task automatic evp(input logic [3:0] v);
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= 4'h0;
		w(4);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Monitor: each result takes the oldest note
	always @(posedge clk_i) begin
		if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0)
			chk($sformatf("reg %h", adr), dr,
				{24'h00_0000, rq.size() > 0 ? rq.pop_front() : 8'hxx});
		if (done === 1'b1)
			chk("token answer", {30'h0000_0000, acked, naked},
				{30'h0000_0000, tq.size() > 0 ? tq.pop_front() : 2'hx});
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] r;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`UODC_A_CTRL, 8'h21);
		chk("pullup", z(pu), 32'h0000_0000);
		rd(8'h3c, 8'h00);
		for (int p = 0; p < 4; p++) begin
			r = xs();
			wr(`UODC_A_TIMER, {r[7], p[1:0], 3'h0, r[1:0]});
			rd(`UODC_A_TIMER, {1'b1, p[1:0], 3'h0, r[1:0]});
		end
		r = xs();
		wr(`UODC_A_OTGEN, {2'h0, r[5:0]});
		rd(`UODC_A_OTGEN, {2'h0, r[5:0]});
		// Only negotiation and VBUS errors may interrupt
		wr(`UODC_A_OTGEN, 8'h12);
		evp(4'h2);
		rd(`UODC_A_OTGFL, 8'h08);
		rd(`UODC_A_CTRL, 8'h21);
		chk("irq", z(irq), 32'h0000_0000);
		evp(4'h4);
		rd(`UODC_A_OTGFL, 8'h18);
		chk("irq", z(irq), 32'h0000_0001);
		wr(`UODC_A_OTGFL, 8'h08);
		evp(4'h1);
		rd(`UODC_A_OTGFL, 8'h0a);
		evp(4'h8);
		rd(`UODC_A_OTGFL, 8'h0a);
		wr(`UODC_A_CTRL, 8'h61);
		evp(4'h8);
		rd(`UODC_A_OTGFL, 8'h0b);
		wr(`UODC_A_OTGFL, 8'h00);
		rd(`UODC_A_OTGFL, 8'h00);
		chk("irq", z(irq), 32'h0000_0000);
		// Power request with no peer, then the clear command
		wr(`UODC_A_OTGCON, 8'h02);
		w(3);
		chk("vbus power", z(vpw), 32'h0000_0001);
		w(40);
		chk("vbus power", z(vpw), 32'h0000_0000);
		rd(`UODC_A_OTGFL, 8'h04);
		conn <= 1'b1;
		wr(`UODC_A_OTGFL, 8'h00);
		wr(`UODC_A_OTGCON, 8'h02);
		w(3);
		chk("vbus power", z(vpw), 32'h0000_0001);
		wr(`UODC_A_OTGCON, 8'h03);
		w(3);
		chk("vbus power", z(vpw), 32'h0000_0000);
		rd(`UODC_A_OTGCON, 8'h00);
		susp <= 1'b1;
		wr(`UODC_A_OTGCON, 8'h20);
		w(30);
		rd(`UODC_A_OTGFL, 8'h20);
		susp <= 1'b0;
		wr(`UODC_A_OTGCON, 8'h00);
		wr(`UODC_A_OTGFL, 8'h00);
		$display("otg tests done");
		// Attach, VBUS loss, bus reset
		wr(`UODC_A_CTRL, 8'h80);
		w(4);
		chk("pullup", z(pu), 32'h0000_0001);
		vbus_on <= 1'b0;
		w(4);
		chk("pullup", z(pu), 32'h0000_0000);
		vbus_on <= 1'b1;
		r = xs();
		spd <= r[0];
		bres();
		rd(`UODC_A_STAT, {4'h1, r[0], 3'h3});
		wr(`UODC_A_EPSEL, 8'h00);
		wr(`UODC_A_EPCFG, 8'h01);
		rd(`UODC_A_EPCFG, 8'h81);
		tk(7'h00, 3'h0, 2'h2);
		tk(7'h00, 3'h7, 2'h0);
		wr(`UODC_A_EPSEL, 8'h01);
		wr(`UODC_A_EPCFG, 8'h3d);
		rd(`UODC_A_EPCFG, 8'h3d);
		tk(7'h00, 3'h1, 2'h1);
		wr(`UODC_A_EPCFG, 8'h3b);
		rd(`UODC_A_EPCFG, 8'hbb);
		tk(7'h00, 3'h1, 2'h2);
		rd(`UODC_A_EPEVT, 8'h03);
		wr(`UODC_A_EPRST, 8'h02);
		rd(`UODC_A_EPEVT, 8'h02);
		rd(`UODC_A_EPCFG, 8'hbb);
		wr(`UODC_A_EPCFG, 8'h3a);
		rd(`UODC_A_EPEVT, 8'h00);
		wr(`UODC_A_EPCFG, 8'h3b);
		tk(7'h00, 3'h1, 2'h2);
		$display("endpoint tests done");
		// Address stored first, enabled by a separate write
		wr(`UODC_A_ADDR, 8'h05);
		tk(7'h05, 3'h0, 2'h0);
		tk(7'h00, 3'h0, 2'h2);
		wr(`UODC_A_ADDR, 8'h85);
		tk(7'h05, 3'h0, 2'h2);
		tk(7'h00, 3'h0, 2'h0);
		bres();
		tk(7'h05, 3'h1, 2'h0);
		tk(7'h00, 3'h1, 2'h1);
		tk(7'h00, 3'h0, 2'h2);
		rd(`UODC_A_ADDR, 8'h00);
		wr(`UODC_A_CTRL, 8'ha0);
		tk(7'h00, 3'h0, 2'h0);
		wr(`UODC_A_STAT, 8'h00);
		bres();
		rd(`UODC_A_STAT, {4'h1, r[0], 3'h3});
		wr(`UODC_A_ADDR, 8'h85);
		wr(`UODC_A_CTRL, 8'h00);
		rd(`UODC_A_ADDR, 8'h00);
		rd(`UODC_A_EPSEL, 8'h00);
		rd(`UODC_A_CTRL, 8'h00);
		$display("address and disable tests done");
		results();
	end
endmodule
